// file: dvc_capability_regs.v
// axi4-lite register bank: serial number and channel capability words
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "dvc_regs.vh"
module dvc_capability_regs #(
  parameter AW = 12
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          cold_resetn,
  input  wire          upstream_strap,
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire [2:0]    s_axi_awprot,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire [2:0]    s_axi_arprot,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  output wire [63:0]   unique_id,
  output reg           unlocked
);
  // write side states
  localparam [1:0] W_COLLECT = 2'b01;
  localparam [1:0] W_RESP    = 2'b10;
  // read side states
  localparam [1:0] R_IDLE    = 2'b01;
  localparam [1:0] R_DATA    = 2'b10;

  reg  [1:0]    wstate;
  reg  [1:0]    next_wstate;
  reg  [1:0]    rstate;
  reg  [1:0]    next_rstate;
  reg           aw_held;
  reg           next_aw_held;
  reg  [AW-1:0] aw_addr;
  reg  [AW-1:0] next_aw_addr;
  reg           w_held;
  reg           next_w_held;
  reg  [31:0]   w_data;
  reg  [31:0]   next_w_data;
  reg  [3:0]    w_strb;
  reg  [3:0]    next_w_strb;
  reg           next_awready;
  reg           next_wready;
  reg           next_bvalid;
  reg  [1:0]    next_bresp;
  reg           next_arready;
  reg           next_rvalid;
  reg  [31:0]   next_rdata;
  reg  [1:0]    next_rresp;
  reg           next_unlocked;
  wire          commit;
  wire          wr_sn_low;
  wire          wr_sn_high;
  wire          wr_vc_hdr;
  wire          wr_lock;
  wire [31:0]   wmask;
  wire [31:0]   sn_low;
  wire [31:0]   sn_high;
  wire [11:0]   next_ptr;
  wire          is_upstream;

  // byte strobes widened to a bit mask
  function [31:0] strb_mask;
    input [3:0] strb;
    begin
      strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  // places a field value at its bit position
  function [31:0] put_field;
    input [31:0] val;
    input [4:0]  lsb;
    begin
      put_field = val << lsb;
    end
  endfunction

  // true when the word offset belongs to this bank
  function addr_hit;
    input [AW-1:0] a;
    begin
      case (a[11:2])
        `DVC_SN_LOW_OFS >> 2:   addr_hit = 1'b1;
        `DVC_SN_HIGH_OFS >> 2:  addr_hit = 1'b1;
        `DVC_VC_HDR_OFS >> 2:   addr_hit = 1'b1;
        `DVC_VC_CAP1_OFS >> 2:  addr_hit = 1'b1;
        `DVC_VC_CAP2_OFS >> 2:  addr_hit = 1'b1;
        `DVC_LOCK_CTL_OFS >> 2: addr_hit = 1'b1;
        default:                addr_hit = 1'b0;
      endcase
    end
  endfunction

  // true when the aligned word offset matches a register offset
  function word_is;
    input [AW-1:0] a;
    input [11:0]   ofs;
    begin
      word_is = (a[11:2] == ofs[11:2]);
    end
  endfunction

  // read data assembly; unlisted bits stay zero
  function [31:0] read_word;
    input [AW-1:0] a;
    input [31:0]   lo;
    input [31:0]   hi;
    input [11:0]   nptr;
    input          up;
    input          unl;
    begin
      read_word = 32'h00000000;
      case (a[11:2])
        `DVC_SN_LOW_OFS >> 2: begin
          read_word = lo;
        end
        `DVC_SN_HIGH_OFS >> 2: begin
          read_word = hi;
        end
        `DVC_VC_HDR_OFS >> 2: begin
          read_word = put_field(`DVC_CAP_ID, `DVC_CAP_ID_LSB)
                    | put_field(`DVC_CAP_VER, `DVC_CAP_VER_LSB)
                    | put_field({20'h00000, nptr}, `DVC_NEXT_PTR_LSB);
        end
        `DVC_VC_CAP1_OFS >> 2: begin
          read_word = put_field(`DVC_EXTRA_CNT, `DVC_EXTRA_CNT_LSB)
                    | put_field(`DVC_LP_CNT, `DVC_LP_CNT_LSB)
                    | put_field(`DVC_TIME_BASE, `DVC_TIME_BASE_LSB)
                    | put_field(up ? `DVC_ENTRY_4BIT : `DVC_ENTRY_1BIT,
                                `DVC_ENTRY_LSB);
        end
        `DVC_VC_CAP2_OFS >> 2: begin
          read_word = put_field(`DVC_ARB_CAP, `DVC_ARB_CAP_LSB)
                    | put_field(`DVC_TBL_OFS, `DVC_TBL_OFS_LSB);
        end
        `DVC_LOCK_CTL_OFS >> 2: begin
          read_word = {31'h00000000, unl};
        end
        default: begin
          read_word = 32'h00000000;
        end
      endcase
    end
  endfunction

  // write commits once address and data are both held
  assign commit     = aw_held & w_held & ~s_axi_bvalid;
  assign wmask      = strb_mask(w_strb);
  assign wr_sn_low  = commit & word_is(aw_addr, `DVC_SN_LOW_OFS);
  assign wr_sn_high = commit & word_is(aw_addr, `DVC_SN_HIGH_OFS);
  assign wr_vc_hdr  = commit & word_is(aw_addr, `DVC_VC_HDR_OFS);
  assign wr_lock    = commit & word_is(aw_addr, `DVC_LOCK_CTL_OFS);
  assign unique_id  = {sn_high, sn_low};

  // port role strap, caught after reset release
  dvc_role_latch u_role (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .strap       (upstream_strap),
    .is_upstream (is_upstream)
  );

  // serial number low half, cleared only by cold reset
  dvc_lock_reg #(
    .W   (32),
    .RST (`DVC_SN_RST)
  ) u_sn_low (
    .aclk     (aclk),
    .rst_n    (cold_resetn),
    .wr_en    (wr_sn_low),
    .unlocked (unlocked),
    .wdata    (w_data),
    .wmask    (wmask),
    .q        (sn_low)
  );

  // serial number high half, cleared only by cold reset
  dvc_lock_reg #(
    .W   (32),
    .RST (`DVC_SN_RST)
  ) u_sn_high (
    .aclk     (aclk),
    .rst_n    (cold_resetn),
    .wr_en    (wr_sn_high),
    .unlocked (unlocked),
    .wdata    (w_data),
    .wmask    (wmask),
    .q        (sn_high)
  );

  // next capability pointer, ordinary reset
  dvc_lock_reg #(
    .W   (12),
    .RST (`DVC_NEXT_PTR_RST)
  ) u_next_ptr (
    .aclk     (aclk),
    .rst_n    (aresetn),
    .wr_en    (wr_vc_hdr),
    .unlocked (unlocked),
    .wdata    (w_data[31:20]),
    .wmask    (wmask[31:20]),
    .q        (next_ptr)
  );

  // write channel next state
  always @* begin
    next_wstate  = wstate;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_unlocked = unlocked;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    case (wstate)
      W_COLLECT: begin
        if (commit) begin
          next_aw_held = 1'b0;
          next_w_held  = 1'b0;
          next_bvalid  = 1'b1;
          next_bresp   = addr_hit(aw_addr) ? `DVC_RESP_OKAY : `DVC_RESP_DECERR;
          next_wstate  = W_RESP;
          if (wr_lock && w_strb[0]) begin
            next_unlocked = w_data[`DVC_UNLOCK_BIT];
          end
        end
      end
      W_RESP: begin
        if (s_axi_bready) begin
          next_bvalid = 1'b0;
          next_wstate = W_COLLECT;
        end
      end
      default: begin
        next_wstate = W_COLLECT;
        next_bvalid = 1'b0;
      end
    endcase
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready  = ~next_w_held & ~next_bvalid;
  end

  // read channel next state
  always @* begin
    next_rstate  = rstate;
    next_arready = s_axi_arready;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    case (rstate)
      R_IDLE: begin
        if (s_axi_arvalid && s_axi_arready) begin
          next_rdata   = read_word(s_axi_araddr, sn_low, sn_high, next_ptr,
                                   is_upstream, unlocked);
          next_rresp   = addr_hit(s_axi_araddr) ? `DVC_RESP_OKAY : `DVC_RESP_DECERR;
          next_rvalid  = 1'b1;
          next_arready = 1'b0;
          next_rstate  = R_DATA;
        end
      end
      R_DATA: begin
        if (s_axi_rready) begin
          next_rvalid  = 1'b0;
          next_arready = 1'b1;
          next_rstate  = R_IDLE;
        end
      end
      default: begin
        next_rstate  = R_IDLE;
        next_rvalid  = 1'b0;
        next_arready = 1'b1;
      end
    endcase
  end

  // write channel registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      wstate        <= W_COLLECT;
      aw_held       <= 1'b0;
      aw_addr       <= {AW{1'b0}};
      w_held        <= 1'b0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DVC_RESP_OKAY;
      unlocked      <= `DVC_LOCK_RST;
    end else begin
      wstate        <= next_wstate;
      aw_held       <= next_aw_held;
      aw_addr       <= next_aw_addr;
      w_held        <= next_w_held;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      unlocked      <= next_unlocked;
    end
  end

  // read channel registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      rstate        <= R_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `DVC_RESP_OKAY;
    end else begin
      rstate        <= next_rstate;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end
endmodule
`default_nettype wire

// file: dvc_capability_regs_properties.sv
// assertion checker for the capability register bank
`timescale 1ns/100ps
`default_nettype none
module dvc_capability_regs_props #(
  parameter AW = 12
) (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          cold_resetn,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic [63:0]   unique_id,
  input wire logic          unlocked
);
  // read request taken this edge
  wire rd_take = s_axi_arvalid && s_axi_arready;
  property p_cap_id;
    @(posedge aclk) disable iff (!aresetn) rd_take && s_axi_araddr == 'h200
      |=> s_axi_rdata[15:0] == 16'h0002;
  endproperty
  a_cap_id: assert property (p_cap_id) else $error("header id wrong");
  property p_cap_ver;
    @(posedge aclk) disable iff (!aresetn) rd_take && s_axi_araddr == 'h200
      |=> s_axi_rdata[19:16] == 4'h1;
  endproperty
  a_cap_ver: assert property (p_cap_ver) else $error("header version wrong");
  property p_cap1;
    @(posedge aclk) disable iff (!aresetn) rd_take && s_axi_araddr == 'h204
      |=> s_axi_rdata[9:0] == 10'h000 && s_axi_rdata[31:12] == 20'h00000;
  endproperty
  a_cap1: assert property (p_cap1) else $error("cap one fields wrong");
  property p_cap2;
    @(posedge aclk) disable iff (!aresetn) rd_take && s_axi_araddr == 'h208
      |=> s_axi_rdata == 32'h00000000;
  endproperty
  a_cap2: assert property (p_cap2) else $error("cap two not zero");
  property p_sticky;
    @(posedge aclk) disable iff (!cold_resetn) !aresetn |=> $stable(unique_id);
  endproperty
  a_sticky: assert property (p_sticky) else $error("serial lost in warm reset");
  property p_locked;
    @(posedge aclk) disable iff (!aresetn) $rose(s_axi_bvalid) && !unlocked
      |-> $stable(unique_id);
  endproperty
  a_locked: assert property (p_locked) else $error("locked serial changed");
  property p_wr_answer;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("no write answer");
  property p_b_hold;
    @(posedge aclk) disable iff (!aresetn) s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    @(posedge aclk) disable iff (!aresetn) rd_take ##1 s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
endmodule
`default_nettype wire

// file: dvc_capability_regs_test.sv
// self-checking bench for the capability register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: %h expected %h", $time, g, e); end end
module dvc_capability_regs_test;
  logic        aclk, aresetn, cold_resetn, upstream_strap;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, unlocked;
  logic [63:0] unique_id;
  int          failures, n_compared, n, ready_lag;
  dvc_capability_regs dut_u (.aclk, .aresetn, .cold_resetn, .upstream_strap,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .unique_id, .unlocked);
  // clock at 100 MHz
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task to_out;
    failures++;
    print_verdict();
  endtask
  // one write, both channels offered together
  task wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (ready_lag == 0);
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
        break;
      end
      if (n + 1 == ready_lag) s_axi_bready <= 1'b1; // late ready, answer must stand
    end
    if (n == 50) to_out();
    @(posedge aclk);
  endtask
  // one read, compared with the expected word
  task rd(input [11:0] a, input [31:0] ed, input [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (ready_lag == 0);
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, ed)
        `CHK(s_axi_rresp, er)
        break;
      end
      if (n + 1 == ready_lag) s_axi_rready <= 1'b1; // late ready, answer must stand
    end
    if (n == 50) to_out();
    @(posedge aclk);
  endtask
  // hold the chosen resets for 16 cycles
  task do_reset(input logic cold);
    aresetn <= 1'b0;
    cold_resetn <= ~cold;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    cold_resetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  task t_defaults;
    rd(12'h184, 32'h00000000, 2'h0);
    rd(12'h188, 32'h00000000, 2'h0);
    rd(12'h200, 32'h00010002, 2'h0);
    rd(12'h204, 32'h00000800, 2'h0);
    rd(12'h208, 32'h00000000, 2'h0);
    $display("test done: defaults");
  endtask
  task t_locked;
    wr(12'h184, 32'hA5A5A5A5, 4'hF, 2'h0);
    wr(12'h200, 32'hFFFFFFFF, 4'hF, 2'h0);
    rd(12'h184, 32'h00000000, 2'h0);
    rd(12'h200, 32'h00010002, 2'h0);
    `CHK(unique_id, 64'h0)
    $display("test done: locked");
  endtask
  task t_unlocked;
    wr(12'h300, 32'h00000001, 4'h1, 2'h0);
    `CHK(unlocked, 1'b1)
    wr(12'h184, 32'h11223344, 4'hF, 2'h0);
    wr(12'h188, 32'h55667788, 4'hF, 2'h0);
    wr(12'h188, 32'hAABBCCDD, 4'h2, 2'h0);
    `CHK(unique_id, 64'h5566CC8811223344)
    rd(12'h188, 32'h5566CC88, 2'h0);
    wr(12'h200, 32'hFFFFFFFF, 4'hF, 2'h0);
    rd(12'h200, 32'hFFF10002, 2'h0);
    wr(12'h204, 32'hFFFFFFFF, 4'hF, 2'h0);
    rd(12'h204, 32'h00000800, 2'h0);
    wr(12'h208, 32'hFFFFFFFF, 4'hF, 2'h0);
    rd(12'h208, 32'h00000000, 2'h0);
    wr(12'h2FC, 32'hFFFFFFFF, 4'hF, 2'h3);
    rd(12'h2FC, 32'h00000000, 2'h3);
    $display("test done: unlocked");
  endtask
  task t_resets;
    upstream_strap <= 1'b0;
    do_reset(1'b0);
    `CHK(unlocked, 1'b0)
    rd(12'h184, 32'h11223344, 2'h0);
    rd(12'h200, 32'h00010002, 2'h0);
    rd(12'h204, 32'h00000000, 2'h0);
    do_reset(1'b1);
    `CHK(unique_id, 64'h0)
    rd(12'h188, 32'h00000000, 2'h0);
    $display("test done: resets");
  endtask
  // answers held while the master is slow to take them
  task t_stall;
    ready_lag = 3;
    wr(12'h184, 32'h99AABBCC, 4'hF, 2'h0);
    rd(12'h184, 32'h99AABBCC, 2'h0);
    ready_lag = 0;
    wr(12'h184, 32'h11223344, 4'hF, 2'h0);
    `CHK(unique_id, 64'h5566CC8811223344)
    $display("test done: stall");
  endtask
  // main sequence
  initial begin
    failures = 0;
    n_compared = 0;
    ready_lag = 0;
    aresetn = 1'b0;
    cold_resetn = 1'b0;
    upstream_strap = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    @(posedge aclk);
    do_reset(1'b1);
    t_defaults();
    t_locked();
    t_unlocked();
    t_stall();
    t_resets();
    print_verdict();
  end
endmodule
bind dvc_capability_regs dvc_capability_regs_props #(.AW(AW)) chk_u (.aclk, .aresetn,
  .cold_resetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .unique_id, .unlocked);
`default_nettype wire

// file: dvc_lock_reg.v
// lock-writable register with bit mask and its own reset
`timescale 1ns/100ps
`default_nettype none
module dvc_lock_reg #(
  parameter       W   = 32,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         aclk,
  input  wire         rst_n,
  input  wire         wr_en,
  input  wire         unlocked,
  input  wire [W-1:0] wdata,
  input  wire [W-1:0] wmask,
  output reg  [W-1:0] q
);
  // masked update, only while unlocked
  always @(posedge aclk) begin
    if (!rst_n) begin
      q <= RST;
    end else if (wr_en && unlocked) begin
      q <= (q & ~wmask) | (wdata & wmask);
    end
  end
endmodule
`default_nettype wire

// file: dvc_regs.vh
// register map constants for the serial number and channel capability bank
`ifndef DVC_REGS_VH
`define DVC_REGS_VH
`define DVC_SN_LOW_OFS 12'h184
`define DVC_SN_HIGH_OFS 12'h188
`define DVC_VC_HDR_OFS 12'h200
`define DVC_VC_CAP1_OFS 12'h204
`define DVC_VC_CAP2_OFS 12'h208
`define DVC_LOCK_CTL_OFS 12'h300
`define DVC_SN_RST 32'h00000000
`define DVC_CAP_ID 32'h00000002
`define DVC_CAP_VER 32'h00000001
`define DVC_NEXT_PTR_RST 12'h000
`define DVC_EXTRA_CNT 32'h00000000
`define DVC_LP_CNT 32'h00000000
`define DVC_TIME_BASE 32'h00000000
`define DVC_ENTRY_1BIT 32'h00000000
`define DVC_ENTRY_2BIT 32'h00000001
`define DVC_ENTRY_4BIT 32'h00000002
`define DVC_ENTRY_8BIT 32'h00000003
`define DVC_ARB_CAP 32'h00000000
`define DVC_TBL_OFS 32'h00000000
`define DVC_CAP_ID_LSB 5'h00
`define DVC_CAP_VER_LSB 5'h10
`define DVC_NEXT_PTR_LSB 5'h14
`define DVC_EXTRA_CNT_LSB 5'h00
`define DVC_LP_CNT_LSB 5'h04
`define DVC_TIME_BASE_LSB 5'h08
`define DVC_ENTRY_LSB 5'h0A
`define DVC_ARB_CAP_LSB 5'h00
`define DVC_TBL_OFS_LSB 5'h18
`define DVC_UNLOCK_BIT 0
`define DVC_LOCK_RST 1'b0
`define DVC_RESP_OKAY 2'h0
`define DVC_RESP_DECERR 2'h3
`endif

// file: dvc_role_latch.v
// captures the port role strap on the first clock after reset release
`timescale 1ns/100ps
`default_nettype none
module dvc_role_latch (
  input  wire aclk,
  input  wire aresetn,
  input  wire strap,
  output reg  is_upstream
);
  reg armed;

  // sample once, then hold until the next reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      armed       <= 1'b1;
      is_upstream <= 1'b0;
    end else if (armed) begin
      armed       <= 1'b0;
      is_upstream <= strap;
    end
  end
endmodule
`default_nettype wire
